// ===== itc_consts.svh
`ifndef ITC_CONSTS_SVH
`define ITC_CONSTS_SVH

// Register offsets on the internal register port
`define ITC_TDR_OFS 8'h08
`define ITC_TCR_OFS 8'h09
`define ITC_MR_OFS 8'h0a

// Reset values
`define ITC_MR_RESET 8'h40
`define ITC_TCR_RESET 8'h50
`define ITC_TDR_RESET 8'hff
`define ITC_PRE_RESET 7'h7f
`define ITC_AUX_MASK_RESET 1'b1

// Field positions
`define ITC_MR_REQ 7
`define ITC_MR_MASK 6
`define ITC_TCR_REQ 7
`define ITC_TCR_PRECLR 3
`define ITC_CC_IBIT 3

// Stack pointer: upper bits fixed, lower bits count
`define ITC_SP_UPPER 8'h03
`define ITC_SP_HOME 6'h3f

// Vector addresses (high byte location of each pair)
`define ITC_VEC_RESET 14'h1ffe
`define ITC_VEC_SWI 14'h1ffc
`define ITC_VEC_INT 14'h1ffa
`define ITC_VEC_TIM 14'h1ff8
`define ITC_VEC_SER 14'h1ff6

// Timer clock source select
`define ITC_SRC_INT 2'h0
`define ITC_SRC_GATED 2'h1
`define ITC_SRC_STOP 2'h2
`define ITC_SRC_EVENT 2'h3

`endif

// ===== itc_pkg.sv
`default_nettype none

package itc_pkg;

  typedef struct packed {
    logic [13:0] pc;
    logic [7:0] x;
    logic [7:0] a;
    logic [4:0] cc;
  } itc_ctx_t;

  typedef struct packed {
    logic req;
    logic mask;
    logic [1:0] src;
    logic preClr;
    logic [2:0] ratio;
  } itc_tcr_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_PUSHPCL = 4'h1,
    S_PUSHPCH = 4'h3,
    S_PUSHX = 4'h2,
    S_PUSHA = 4'h6,
    S_PUSHCC = 4'h7,
    S_VEC = 4'h5,
    S_PULLCC = 4'h4,
    S_PULLA = 4'hc,
    S_PULLX = 4'hd,
    S_PULLPCH = 4'hf,
    S_PULLPCL = 4'he,
    S_RESUME = 4'ha,
    S_RSTVEC = 4'h8
  } itc_state_t;

endpackage

`default_nettype wire

// ===== itc_edge_latch.sv
`timescale 1ns/100ps
`default_nettype none

module itc_edge_latch (
  input wire logic sys_clk, // Bus-phase clock
  input wire logic resetn, // Async reset, active low
  input wire logic pinIn, // Request pin, active low
  input wire logic clrReq, // Clear the latched request
  output logic reqOut, // Latched falling-edge request
  output logic levelOut // Registered pin level
);

  logic prev_ff;
  logic req_ff;
  logic nxt_prev;
  logic nxt_req;
  logic fall;

  always_comb begin
    fall = prev_ff & ~pinIn;
    nxt_prev = pinIn;
    // A new edge wins over a clear in the same cycle
    nxt_req = fall | (req_ff & ~clrReq);
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      prev_ff <= 1'b1;
      req_ff <= 1'b0;
    end else begin
      prev_ff <= nxt_prev;
      req_ff <= nxt_req;
    end
  end

  assign reqOut = req_ff;
  assign levelOut = prev_ff;

  a_edge_latched: assert property (@(posedge sys_clk) disable iff (!resetn)
    fall |=> reqOut)
    else $error("edge not latched");

  a_level_direct: assert property (@(posedge sys_clk) disable iff (!resetn)
    ##1 levelOut == $past(pinIn))
    else $error("pin level not passed through");

  a_req_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
    (reqOut && !clrReq) |=> reqOut)
    else $error("latched request lost without clear");

endmodule

`default_nettype wire

// ===== itc_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "itc_consts.svh"

module itc_top (
  input wire logic sys_clk, // Bus-phase clock
  input wire logic resetn, // Async reset, active low
  input wire logic instrBoundary, // Core at an instruction boundary
  input wire logic swiExec, // Soft trap opcode at this boundary
  input wire logic rtiExec, // Return-from-handler opcode
  input wire logic jsrExec, // Subroutine call opcode
  input wire logic rtsExec, // Subroutine return opcode
  input wire logic rspExec, // Stack-home opcode
  input wire logic cliExec, // Mask flag clear opcode
  input wire logic seiExec, // Mask flag set opcode
  input wire itc_pkg::itc_ctx_t ctxIn, // Live core context
  input wire logic [7:0] stackRdData, // Stack read data, same cycle
  input wire logic intPinN, // Primary request pin, active low
  input wire logic int2PinN, // Secondary request pin, active low
  input wire logic timerPin, // Timer input pin
  input wire logic serialReq, // Serial done flag
  input wire logic serialMask, // Serial mask bit
  input wire logic secondTickReq, // Second tick flag
  input wire logic secondTickMask, // Second tick mask bit
  input wire logic [7:0] regAddr, // Register address
  input wire logic regWrEn, // Register write strobe
  input wire logic regRdEn, // Register read strobe
  input wire logic [7:0] regWrData, // Register write data
  output logic [7:0] regRdData, // Register read data
  output logic busy, // Core halted for sequencing
  output logic stackWrEn, // Stack write strobe
  output logic stackRdEn, // Stack read strobe
  output logic [13:0] stackAddr, // Stack address
  output logic [7:0] stackWrData, // Stack write data
  output logic vecValid, // Vector fetch pulse
  output logic [13:0] vecAddr, // Vector location
  output logic ctxValid, // Pulled context valid pulse
  output itc_pkg::itc_ctx_t ctxOut, // Pulled context
  output logic iFlag, // Global mask flag
  output logic intLevel, // Primary pin level for branches
  output logic int2Level // Secondary pin level for branches
);

  itc_pkg::itc_state_t state_ff, nxt_state;
  itc_pkg::itc_ctx_t saved_ff, nxt_saved, ctx_ff, nxt_ctx;
  itc_pkg::itc_tcr_t tcr_ff, nxt_tcr;
  logic [5:0] sp_ff, nxt_sp, spInc;
  logic isCall_ff, nxt_isCall;
  logic wrEn_ff, nxt_wrEn, rdEn_ff, nxt_rdEn;
  logic [13:0] addr_ff, nxt_addr, vec_ff, nxt_vec;
  logic [7:0] wrData_ff, nxt_wrData;
  logic vecValid_ff, nxt_vecValid, ctxValid_ff, nxt_ctxValid;
  logic iFlag_ff, nxt_iFlag, busy_ff;
  logic mrMask_ff, nxt_mrMask;
  logic [6:0] pre_ff, nxt_pre, divMask;
  logic [7:0] tdr_ff, nxt_tdr, divOne;
  logic tmrPrev_ff, srcTick, divTick, zeroHit;
  logic [7:0] rdData_ff, nxt_rdData;
  logic int1Req, int2Req, int1Clr, int2Clr;
  logic pInt, pTim, pSer, intTake;
  logic wrMr, wrTcr, wrTdr;

  always_comb begin
    wrMr = regWrEn && regAddr == `ITC_MR_OFS;
    wrTcr = regWrEn && regAddr == `ITC_TCR_OFS;
    wrTdr = regWrEn && regAddr == `ITC_TDR_OFS;
  end

  // Edge latches for both request pins
  itc_edge_latch u_int1 (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .pinIn(intPinN),
    .clrReq(int1Clr),
    .reqOut(int1Req),
    .levelOut(intLevel)
  );

  itc_edge_latch u_edge_request_secondary (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .pinIn(int2PinN),
    .clrReq(int2Clr),
    .reqOut(int2Req),
    .levelOut(int2Level)
  );

  // Pending sources after their own masks; the primary pin request has no mask of its own
  always_comb begin
    pInt = int1Req;
    pTim = (tcr_ff.req & ~tcr_ff.mask) | (int2Req & ~mrMask_ff);
    pSer = (serialReq & ~serialMask) | (secondTickReq & ~secondTickMask);
    intTake = state_ff == itc_pkg::S_IDLE && instrBoundary && !iFlag_ff &&
              !swiExec && !jsrExec && !rtiExec && !rtsExec &&
              (pInt | pTim | pSer);
    int1Clr = state_ff == itc_pkg::S_VEC && vec_ff == `ITC_VEC_INT;
    int2Clr = wrMr && !regWrData[`ITC_MR_REQ];
  end

  // Entry, stacking and return sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_saved = saved_ff;
    nxt_ctx = ctx_ff;
    nxt_sp = sp_ff;
    nxt_isCall = isCall_ff;
    nxt_wrEn = 1'b0;
    nxt_rdEn = 1'b0;
    nxt_addr = addr_ff;
    nxt_wrData = wrData_ff;
    nxt_vecValid = 1'b0;
    nxt_vec = vec_ff;
    nxt_ctxValid = 1'b0;
    nxt_iFlag = iFlag_ff;
    spInc = sp_ff + 6'h01;
    case (state_ff)
      itc_pkg::S_RSTVEC: begin
        nxt_vecValid = 1'b1;
        nxt_vec = `ITC_VEC_RESET;
        nxt_state = itc_pkg::S_IDLE;
      end
      itc_pkg::S_IDLE: begin
        if (instrBoundary) begin
          if (cliExec) begin
            nxt_iFlag = 1'b0;
          end
          if (seiExec) begin
            nxt_iFlag = 1'b1;
          end
          if (rspExec) begin
            nxt_sp = `ITC_SP_HOME;
          end
          nxt_saved = ctxIn;
          nxt_isCall = 1'b0;
          if (swiExec) begin
            nxt_vec = `ITC_VEC_SWI;
            nxt_state = itc_pkg::S_PUSHPCL;
          end else if (jsrExec) begin
            nxt_isCall = 1'b1;
            nxt_state = itc_pkg::S_PUSHPCL;
          end else if (rtiExec) begin
            nxt_state = itc_pkg::S_PULLCC;
          end else if (rtsExec) begin
            nxt_isCall = 1'b1;
            nxt_state = itc_pkg::S_PULLPCH;
          end else if (intTake) begin
            nxt_state = itc_pkg::S_PUSHPCL;
            if (pInt) begin
              nxt_vec = `ITC_VEC_INT;
            end else if (pTim) begin
              nxt_vec = `ITC_VEC_TIM;
            end else begin
              nxt_vec = `ITC_VEC_SER;
            end
          end
        end
      end
      itc_pkg::S_PUSHPCL: begin
        nxt_wrEn = 1'b1;
        nxt_addr = {`ITC_SP_UPPER, sp_ff};
        nxt_wrData = saved_ff.pc[7:0];
        nxt_sp = sp_ff - 6'h01;
        nxt_state = itc_pkg::S_PUSHPCH;
      end
      itc_pkg::S_PUSHPCH: begin
        nxt_wrEn = 1'b1;
        nxt_addr = {`ITC_SP_UPPER, sp_ff};
        nxt_wrData = {2'h0, saved_ff.pc[13:8]};
        nxt_sp = sp_ff - 6'h01;
        nxt_state = isCall_ff ? itc_pkg::S_IDLE : itc_pkg::S_PUSHX;
      end
      itc_pkg::S_PUSHX: begin
        nxt_wrEn = 1'b1;
        nxt_addr = {`ITC_SP_UPPER, sp_ff};
        nxt_wrData = saved_ff.x;
        nxt_sp = sp_ff - 6'h01;
        nxt_state = itc_pkg::S_PUSHA;
      end
      itc_pkg::S_PUSHA: begin
        nxt_wrEn = 1'b1;
        nxt_addr = {`ITC_SP_UPPER, sp_ff};
        nxt_wrData = saved_ff.a;
        nxt_sp = sp_ff - 6'h01;
        nxt_state = itc_pkg::S_PUSHCC;
      end
      itc_pkg::S_PUSHCC: begin
        nxt_wrEn = 1'b1;
        nxt_addr = {`ITC_SP_UPPER, sp_ff};
        nxt_wrData = {3'h0, saved_ff.cc};
        nxt_sp = sp_ff - 6'h01;
        nxt_state = itc_pkg::S_VEC;
      end
      itc_pkg::S_VEC: begin
        nxt_vecValid = 1'b1;
        nxt_iFlag = 1'b1;
        nxt_state = itc_pkg::S_IDLE;
      end
      itc_pkg::S_PULLCC: begin
        nxt_sp = spInc;
        nxt_rdEn = 1'b1;
        nxt_addr = {`ITC_SP_UPPER, spInc};
        nxt_state = itc_pkg::S_PULLA;
      end
      itc_pkg::S_PULLA: begin
        nxt_ctx.cc = stackRdData[4:0];
        nxt_iFlag = stackRdData[`ITC_CC_IBIT];
        nxt_sp = spInc;
        nxt_rdEn = 1'b1;
        nxt_addr = {`ITC_SP_UPPER, spInc};
        nxt_state = itc_pkg::S_PULLX;
      end
      itc_pkg::S_PULLX: begin
        nxt_ctx.a = stackRdData;
        nxt_sp = spInc;
        nxt_rdEn = 1'b1;
        nxt_addr = {`ITC_SP_UPPER, spInc};
        nxt_state = itc_pkg::S_PULLPCH;
      end
      itc_pkg::S_PULLPCH: begin
        if (!isCall_ff) begin
          nxt_ctx.x = stackRdData;
        end
        nxt_sp = spInc;
        nxt_rdEn = 1'b1;
        nxt_addr = {`ITC_SP_UPPER, spInc};
        nxt_state = itc_pkg::S_PULLPCL;
      end
      itc_pkg::S_PULLPCL: begin
        nxt_ctx.pc[13:8] = stackRdData[5:0];
        nxt_sp = spInc;
        nxt_rdEn = 1'b1;
        nxt_addr = {`ITC_SP_UPPER, spInc};
        nxt_state = itc_pkg::S_RESUME;
      end
      itc_pkg::S_RESUME: begin
        nxt_ctx.pc[7:0] = stackRdData;
        nxt_ctxValid = 1'b1;
        nxt_state = itc_pkg::S_IDLE;
      end
      default: begin
        nxt_state = itc_pkg::S_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= itc_pkg::S_RSTVEC;
      saved_ff <= '0;
      ctx_ff <= '0;
      sp_ff <= `ITC_SP_HOME;
      isCall_ff <= 1'b0;
      wrEn_ff <= 1'b0;
      rdEn_ff <= 1'b0;
      addr_ff <= {`ITC_SP_UPPER, `ITC_SP_HOME};
      wrData_ff <= 8'h00;
      vecValid_ff <= 1'b0;
      vec_ff <= `ITC_VEC_RESET;
      ctxValid_ff <= 1'b0;
      iFlag_ff <= 1'b1;
      busy_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      saved_ff <= nxt_saved;
      ctx_ff <= nxt_ctx;
      sp_ff <= nxt_sp;
      isCall_ff <= nxt_isCall;
      wrEn_ff <= nxt_wrEn;
      rdEn_ff <= nxt_rdEn;
      addr_ff <= nxt_addr;
      wrData_ff <= nxt_wrData;
      vecValid_ff <= nxt_vecValid;
      vec_ff <= nxt_vec;
      ctxValid_ff <= nxt_ctxValid;
      iFlag_ff <= nxt_iFlag;
      busy_ff <= nxt_state != itc_pkg::S_IDLE;
    end
  end

  // Tick prescaler, counter and control registers
  always_comb begin
    case (tcr_ff.src)
      `ITC_SRC_INT: srcTick = 1'b1;
      `ITC_SRC_GATED: srcTick = timerPin;
      `ITC_SRC_STOP: srcTick = 1'b0;
      `ITC_SRC_EVENT: srcTick = timerPin & ~tmrPrev_ff;
      default: srcTick = 1'b0;
    endcase
    divOne = 8'h01 << tcr_ff.ratio;
    divMask = divOne[6:0] - 7'h01;
    divTick = srcTick && (pre_ff & divMask) == 7'h00;
    zeroHit = divTick && !wrTdr && tdr_ff == 8'h01;
    nxt_pre = pre_ff;
    if (wrTcr && regWrData[`ITC_TCR_PRECLR]) begin
      nxt_pre = `ITC_PRE_RESET;
    end else if (srcTick) begin
      nxt_pre = pre_ff - 7'h01;
    end
    nxt_tdr = tdr_ff;
    if (wrTdr) begin
      nxt_tdr = regWrData;
    end else if (divTick) begin
      nxt_tdr = tdr_ff - 8'h01;
    end
    nxt_tcr = tcr_ff;
    nxt_mrMask = mrMask_ff;
    if (wrTcr) begin
      nxt_tcr.mask = regWrData[6];
      nxt_tcr.src = regWrData[5:4];
      nxt_tcr.ratio = regWrData[2:0];
    end
    nxt_tcr.preClr = 1'b0;
    // Flag is set by the counter, cleared only by writing 0
    nxt_tcr.req = zeroHit |
                  (tcr_ff.req & ~(wrTcr & ~regWrData[`ITC_TCR_REQ]));
    if (wrMr) begin
      nxt_mrMask = regWrData[`ITC_MR_MASK];
    end
    nxt_rdData = rdData_ff;
    if (regRdEn) begin
      case (regAddr)
        `ITC_MR_OFS: nxt_rdData = {int2Req, mrMask_ff, 6'h00};
        `ITC_TCR_OFS: nxt_rdData = tcr_ff;
        `ITC_TDR_OFS: nxt_rdData = tdr_ff;
        default: nxt_rdData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pre_ff <= `ITC_PRE_RESET;
      tdr_ff <= `ITC_TDR_RESET;
      tcr_ff <= `ITC_TCR_RESET;
      mrMask_ff <= `ITC_AUX_MASK_RESET;
      tmrPrev_ff <= 1'b0;
      rdData_ff <= 8'h00;
    end else begin
      pre_ff <= nxt_pre;
      tdr_ff <= nxt_tdr;
      tcr_ff <= nxt_tcr;
      mrMask_ff <= nxt_mrMask;
      tmrPrev_ff <= timerPin;
      rdData_ff <= nxt_rdData;
    end
  end

  assign regRdData = rdData_ff;
  assign busy = busy_ff;
  assign stackWrEn = wrEn_ff;
  assign stackRdEn = rdEn_ff;
  assign stackAddr = addr_ff;
  assign stackWrData = wrData_ff;
  assign vecValid = vecValid_ff;
  assign vecAddr = vec_ff;
  assign ctxValid = ctxValid_ff;
  assign ctxOut = ctx_ff;
  assign iFlag = iFlag_ff;

  a_mask_holds: assert property (@(posedge sys_clk) disable iff (!resetn)
    (state_ff == itc_pkg::S_IDLE && instrBoundary && iFlag_ff && !swiExec && !jsrExec)
    |=> state_ff != itc_pkg::S_PUSHPCL)
    else $error("masked request entered");

  a_entry_vector: assert property (@(posedge sys_clk) disable iff (!resetn)
    (state_ff == itc_pkg::S_PUSHPCL && !isCall_ff) |-> ##6 (vecValid_ff && iFlag_ff))
    else $error("entry did not vector with mask set");

  a_push_count: assert property (@(posedge sys_clk) disable iff (!resetn)
    (state_ff == itc_pkg::S_PUSHPCL && !isCall_ff) |=> stackWrEn [*5] ##1 !stackWrEn)
    else $error("interrupt stacking not five bytes");

  a_call_push: assert property (@(posedge sys_clk) disable iff (!resetn)
    (state_ff == itc_pkg::S_PUSHPCL && isCall_ff) |=> stackWrEn [*2] ##1 !stackWrEn)
    else $error("call stacking not two bytes");

  a_stack_page: assert property (@(posedge sys_clk) disable iff (!resetn)
    (stackWrEn || stackRdEn) |-> stackAddr[13:6] == `ITC_SP_UPPER)
    else $error("stack left its page");

  a_prio_int: assert property (@(posedge sys_clk) disable iff (!resetn)
    (intTake && pInt) |=> vecAddr == `ITC_VEC_INT)
    else $error("primary edge not highest maskable");

  a_shared_vec: assert property (@(posedge sys_clk) disable iff (!resetn)
    (intTake && !pInt && pTim) |=> vecAddr == `ITC_VEC_TIM)
    else $error("timer group vector wrong");

  a_count_wrap: assert property (@(posedge sys_clk) disable iff (!resetn)
    (divTick && !wrTdr && tdr_ff == 8'h00) |=> tdr_ff == 8'hff)
    else $error("counter did not wrap");

  a_tick_flag: assert property (@(posedge sys_clk) disable iff (!resetn)
    zeroHit |=> (tcr_ff.req && tdr_ff == 8'h00))
    else $error("zero did not raise tick flag");

endmodule

`default_nettype wire

// ===== itc_core_model.sv
`timescale 1ns/100ps
`default_nettype none

module itc_core_model (
  input wire logic sys_clk, // Bus-phase clock
  input wire logic stackWrEn, // Push strobe
  input wire logic stackRdEn, // Pull strobe
  input wire logic [13:0] stackAddr, // Stack address
  input wire logic [7:0] stackWrData, // Pushed byte
  output logic [7:0] stackRdData // Pulled byte, same cycle
);
  logic [7:0] mem [0:63];
  logic [7:0] lastRd = 8'h00;
  int wrCount = 0;
  int rdCount = 0;

  // Outside a pull the data lines show the inverse of the last byte, never a stale copy
  always_comb begin
    if (stackRdEn) begin
      stackRdData = mem[stackAddr[5:0]];
    end else begin
      stackRdData = ~lastRd;
    end
  end

  always @(posedge sys_clk) begin
    if (stackWrEn) begin
      mem[stackAddr[5:0]] <= stackWrData;
      wrCount <= wrCount + 1;
    end
    if (stackRdEn) begin
      lastRd <= mem[stackAddr[5:0]];
      rdCount <= rdCount + 1;
    end
  end
endmodule

`default_nettype wire

// ===== testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench;
  localparam logic [6:0] OP_SWI = 7'h40;
  localparam logic [6:0] OP_RTI = 7'h20;
  localparam logic [6:0] OP_JSR = 7'h10;
  localparam logic [6:0] OP_RTS = 7'h08;
  localparam logic [6:0] OP_RSP = 7'h04;
  localparam logic [6:0] OP_CLI = 7'h02;
  localparam logic [6:0] OP_SEI = 7'h01;

  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic instrBoundary = 1'b0;
  logic [6:0] ops = 7'h00;
  itc_pkg::itc_ctx_t ctxIn = '0;
  logic intPinN = 1'b1;
  logic int2PinN = 1'b1;
  logic timerPin = 1'b0;
  logic serialReq = 1'b0;
  logic serialMask = 1'b1;
  logic secondTickReq = 1'b0;
  logic secondTickMask = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [7:0] regRdData, stackWrData, stackRdData;
  logic busy, stackWrEn, stackRdEn, vecValid, ctxValid, iFlag, intLevel, int2Level;
  logic [13:0] stackAddr, vecAddr;
  itc_pkg::itc_ctx_t ctxOut, ctxSeen;
  logic [13:0] vecSeen;
  int fail_count = 0;
  int checked = 0;
  int i, w0;
  logic [7:0] stk [5] = '{8'h34, 8'h12, 8'h56, 8'h78, 8'h05};
  logic [7:0] msk [5] = '{8'hff, 8'h3f, 8'hff, 8'hff, 8'h1f};

  always #4 sys_clk = ~sys_clk;

  itc_top u_dut (
    .sys_clk(sys_clk), .resetn(resetn), .instrBoundary(instrBoundary),
    .swiExec(ops[6]), .rtiExec(ops[5]), .jsrExec(ops[4]), .rtsExec(ops[3]),
    .rspExec(ops[2]), .cliExec(ops[1]), .seiExec(ops[0]), .ctxIn(ctxIn),
    .stackRdData(stackRdData), .intPinN(intPinN), .int2PinN(int2PinN),
    .timerPin(timerPin), .serialReq(serialReq), .serialMask(serialMask),
    .secondTickReq(secondTickReq), .secondTickMask(secondTickMask),
    .regAddr(regAddr), .regWrEn(regWrEn), .regRdEn(regRdEn), .regWrData(regWrData),
    .regRdData(regRdData), .busy(busy), .stackWrEn(stackWrEn), .stackRdEn(stackRdEn),
    .stackAddr(stackAddr), .stackWrData(stackWrData), .vecValid(vecValid),
    .vecAddr(vecAddr), .ctxValid(ctxValid), .ctxOut(ctxOut), .iFlag(iFlag),
    .intLevel(intLevel), .int2Level(int2Level)
  );

  itc_core_model u_core (
    .sys_clk(sys_clk), .stackWrEn(stackWrEn), .stackRdEn(stackRdEn),
    .stackAddr(stackAddr), .stackWrData(stackWrData), .stackRdData(stackRdData)
  );

  task automatic finish_test();
    $display("Checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [34:0] seen, input logic [34:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    cyc(1);
    regWrEn = 1'b0;
    cyc(1);
  endtask

  task automatic rdv(input logic [7:0] a);
    regAddr = a;
    regRdEn = 1'b1;
    cyc(1);
    regRdEn = 1'b0;
    cyc(1);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    rdv(a);
    chk(regRdData, e);
  endtask

  // Collects vector and pulled context until the sequencer is idle again
  task automatic wait_idle();
    int k;
    vecSeen = '0;
    ctxSeen = '0;
    for (k = 0; k < 30; k++) begin
      if (vecValid === 1'b1) vecSeen = vecAddr;
      if (ctxValid === 1'b1) ctxSeen = ctxOut;
      if (busy === 1'b0) break;
      cyc(1);
    end
    if (k == 30) begin
      fail_count++;
      finish_test();
    end
  endtask

  task automatic step(input logic [6:0] o);
    ops = o;
    instrBoundary = 1'b1;
    cyc(1);
    instrBoundary = 1'b0;
    ops = 7'h00;
    wait_idle();
    cyc(1);
  endtask

  // Clear the mask, give one more boundary, expect entry at vector e, none if e is zero; return if e is nonzero
  task automatic enter(input logic [13:0] e);
    logic [13:0] v;
    step(OP_CLI);
    v = vecSeen;
    step(7'h00);
    v = v | vecSeen;
    chk(v, e);
    if (e != 14'h0000) step(OP_RTI);
  endtask

  initial begin
    cyc(5);
    resetn = 1'b1;
    wait_idle();
    chk(vecSeen, 14'h1ffe);
    chk(iFlag, 1'b1);
    rdchk(8'h0a, 8'h40);
    rdchk(8'h09, 8'h50);
    rdchk(8'h08, 8'hff);
    $display("reset values done");

    intPinN = 1'b0;
    cyc(2);
    chk(intLevel, 1'b0);
    step(7'h00);
    chk(vecSeen, 14'h0000);
    step(OP_CLI);
    chk(vecSeen, 14'h0000);
    ctxIn = {14'h1234, 8'h56, 8'h78, 5'h05};
    w0 = u_core.wrCount;
    step(7'h00);
    chk(vecSeen, 14'h1ffa);
    chk(iFlag, 1'b1);
    chk(u_core.wrCount - w0, 5);
    for (i = 0; i < 5; i++) chk(u_core.mem[63 - i] & msk[i], stk[i]);
    w0 = u_core.rdCount;
    step(OP_RTI);
    chk(ctxSeen, ctxIn);
    chk(u_core.rdCount - w0, 5);
    enter(14'h0000);
    step(OP_SEI);
    step(OP_SWI);
    chk(vecSeen, 14'h1ffc);
    step(OP_RTI);
    $display("entry and return done");

    intPinN = 1'b1;
    wr(8'h0a, 8'h00);
    int2PinN = 1'b0;
    cyc(1);
    intPinN = 1'b0;
    cyc(2);
    chk(int2Level, 1'b0);
    rdchk(8'h0a, 8'h80);
    enter(14'h1ffa);
    enter(14'h1ff8);
    rdchk(8'h0a, 8'h80);
    wr(8'h0a, 8'h80);
    rdchk(8'h0a, 8'h80);
    wr(8'h0a, 8'h00);
    rdchk(8'h0a, 8'h00);
    enter(14'h0000);
    int2PinN = 1'b1;
    wr(8'h0a, 8'h40);
    int2PinN = 1'b0;
    cyc(2);
    enter(14'h0000);
    rdchk(8'h0a, 8'hc0);
    serialMask = 1'b0;
    serialReq = 1'b1;
    enter(14'h1ff6);
    serialReq = 1'b0;
    secondTickReq = 1'b1;
    enter(14'h0000);
    secondTickMask = 1'b0;
    enter(14'h1ff6);
    secondTickReq = 1'b0;
    $display("sources and priority done");

    wr(8'h09, 8'h20);
    wr(8'h08, 8'h05);
    rdchk(8'h08, 8'h05);
    rdchk(8'h08, 8'h05);
    wr(8'h09, 8'h10);
    cyc(8);
    rdchk(8'h08, 8'h05);
    wr(8'h09, 8'h00);
    for (i = 0; i < 40; i++) begin
      rdv(8'h09);
      if (regRdData[7] === 1'b1) break;
    end
    chk(regRdData, 8'h80);
    wr(8'h09, 8'he0);
    enter(14'h0000);
    wr(8'h09, 8'ha0);
    enter(14'h1ff8);
    rdchk(8'h09, 8'ha0);
    wr(8'h09, 8'h28);
    rdchk(8'h09, 8'h20);
    wr(8'h08, 8'h02);
    wr(8'h09, 8'h30);
    repeat (2) begin
      timerPin = 1'b1;
      cyc(3);
      timerPin = 1'b0;
      cyc(3);
    end
    rdchk(8'h08, 8'h00);
    rdchk(8'h09, 8'hb0);
    timerPin = 1'b1;
    cyc(3);
    rdchk(8'h08, 8'hff);
    $display("timer done");

    // Tick flag cleared and masked so that no entry moves the stack here
    wr(8'h09, 8'h60);
    w0 = u_core.wrCount;
    step(OP_JSR);
    chk(vecSeen, 14'h0000);
    chk(u_core.wrCount - w0, 2);
    step(OP_RSP);
    ctxIn.pc = 14'h0abc;
    step(OP_JSR);
    chk(u_core.mem[63], 8'hbc);
    chk(u_core.mem[62], 8'h0a);
    w0 = u_core.rdCount;
    step(OP_RTS);
    chk(ctxSeen.pc, 14'h0abc);
    chk(u_core.rdCount - w0, 2);
    $display("call and stack home done");
    finish_test();
  end
endmodule

`default_nettype wire
